// ==== rtl/event_processor_array_pkg.sv ====
// Constants, register map and carrier types of the capture/compare array.
// Assumes a 32-bit APB register bus and one system clock for all logic.

package event_processor_array_pkg;

  // ==========================================================
  // Sizes
  localparam int NCH        = 4;
  localparam int TW         = 16;
  localparam int DW         = 32;
  localparam int AW         = 8;
  localparam int STABLE_CYC = 2;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [AW-1:0] ADDR_CTL0   = 8'h00;
  localparam logic [AW-1:0] ADDR_TIME0  = 8'h04;
  localparam logic [AW-1:0] ADDR_PEND   = 8'h20;
  localparam logic [AW-1:0] ADDR_PERIOD = 8'h24;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h28;
  localparam int            CH_LSB      = 3;
  localparam int            CH_MSB      = 4;
  localparam int            REG_SEL_BIT = 2;
  localparam int            ALIGN_MSB   = 1;

  // ==========================================================
  // Field layouts and reset values
  localparam int            PEND_OVR_LSB = 4;
  localparam int            STAT_TV_LSB  = 4;
  localparam int            STAT_PIN_LSB = 8;
  localparam int            CTL_W        = 16;
  localparam logic [15:0]   CTL_WMASK    = 16'h01FF;
  localparam logic [15:0]   CTL_RST      = 16'h0000;
  localparam logic [TW-1:0] PERIOD_RST   = 16'h0000;

  // Pin actions in compare mode
  localparam logic [1:0] ACT_HIGH   = 2'h1;
  localparam logic [1:0] ACT_LOW    = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // Edge select bits in capture mode
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [6:0] rsvd;
    logic       pair;
    logic       ovr_ie;
    logic       ch_ie;
    logic [1:0] action;
    logic       rearm;
    logic       tmr_sel;
    logic       capture;
    logic       overwrite;
  } chan_ctl_t;

  // Bits are {buffer valid, event time valid}
  typedef enum logic [1:0] {
    CS_EMPTY = 2'b00,
    CS_TIME  = 2'b01,
    CS_BOTH  = 2'b11,
    CS_BUF   = 2'b10
  } cap_state_t;

  typedef enum logic [2:0] {
    RG_NONE,
    RG_CTL,
    RG_TIME,
    RG_PEND,
    RG_PERIOD,
    RG_STATUS
  } reg_region_t;

  typedef struct packed {
    logic [1:0]  chan;
    reg_region_t region;
  } reg_sel_t;

endpackage

// ==== rtl/edge_qualifier.sv ====
// Qualifies edges on one channel pin for capture.
// Assumes the pin is synchronous to clk; an edge counts only when the
// level was steady STABLE cycles before and after the transition.

`timescale 1ns/1ps

module edge_qualifier
  import event_processor_array_pkg::*;
#(
  parameter int STABLE = STABLE_CYC
)
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       pin_in,
  input  wire logic [1:0] edge_sel,
  output logic            edge_valid
);

  localparam int            HW       = 2 * STABLE;
  localparam logic [HW-1:0] RISE_PAT = {{STABLE{1'b0}}, {STABLE{1'b1}}};
  localparam logic [HW-1:0] FALL_PAT = ~RISE_PAT;

  logic [HW-1:0] hist_ff;

  // ==========================================================
  // Pin history, newest sample in bit 0
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      hist_ff <= '0;
    else
      hist_ff <= {hist_ff[HW-2:0], pin_in};
  end

  // Steady-before-and-after pattern match
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      edge_valid <= 1'b0;
    else
      edge_valid <= (edge_sel[EDGE_RISE_BIT] && (hist_ff == RISE_PAT)) ||
                    (edge_sel[EDGE_FALL_BIT] && (hist_ff == FALL_PAT));
  end

endmodule

// ==== rtl/capture_store.sv ====
// One-entry capture buffer in front of the event-time register.
// Assumes clr, load and cap_edge are single-cycle strobes from the top.

`timescale 1ns/1ps

module capture_store
  import event_processor_array_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          overwrite,
  input  wire logic          cap_edge,
  input  wire logic [TW-1:0] timer_val,
  input  wire logic          clr,
  input  wire logic          load_en,
  input  wire logic [TW-1:0] load_val,
  output logic [TW-1:0]      time_q,
  output cap_state_t         state_q,
  output logic               xfer,
  output logic               ovr
);

  cap_state_t    state_ff;
  cap_state_t    nxt_state;
  logic [TW-1:0] buf_ff;
  logic          buf_ld;

  // ==========================================================
  // Occupancy sequencing
  always_comb
  begin
    nxt_state = state_ff;
    xfer      = 1'b0;
    ovr       = 1'b0;
    buf_ld    = 1'b0;
    case (state_ff)
      CS_EMPTY:
        if (cap_edge)
        begin
          buf_ld    = 1'b1;
          nxt_state = CS_BUF;
        end
      CS_TIME:
        if (cap_edge)
        begin
          buf_ld    = 1'b1;
          nxt_state = clr ? CS_BUF : CS_BOTH;
        end
        else if (clr)
          nxt_state = CS_EMPTY;
      CS_BOTH:
        if (cap_edge)
        begin
          ovr    = 1'b1;
          buf_ld = overwrite;
          // Read coinciding with an overwrite is lost; stays full
          if (clr && !overwrite)
            nxt_state = CS_BUF;
          else
            nxt_state = CS_BOTH;
        end
        else if (clr)
          nxt_state = CS_BUF;
      CS_BUF:
      begin
        xfer = 1'b1;
        if (cap_edge)
        begin
          buf_ld    = 1'b1;
          nxt_state = CS_BOTH;
        end
        else
          nxt_state = CS_TIME;
      end
      default:
        nxt_state = CS_EMPTY;
    endcase
    if (load_en)
      nxt_state = cap_state_t'({nxt_state[1], 1'b1});
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_ff <= CS_EMPTY;
    else
      state_ff <= nxt_state;
  end

  // Capture buffer, one entry
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      buf_ff <= '0;
    else if (buf_ld)
      buf_ff <= timer_val;
  end

  // Event-time register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      time_q <= '0;
    else if (load_en)
      time_q <= load_val;
    else if (xfer)
      time_q <= buf_ff;
  end

  assign state_q = state_ff;

endmodule

// ==== rtl/event_processor_array.sv ====
// Four capture/compare channels with an APB register file.
// Assumes two shared timers arrive as synchronous count values and the
// channel pins are synchronous to clk; all logic runs on clk.

`timescale 1ns/1ps

module event_processor_array
  import event_processor_array_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [AW-1:0]  paddr,
  input  wire logic [DW-1:0]  pwdata,
  output logic [DW-1:0]       prdata,
  output logic                pready,
  output logic                pslverr,
  input  wire logic [TW-1:0]  timer_a,
  input  wire logic [TW-1:0]  timer_b,
  input  wire logic [NCH-1:0] pin_in,
  output logic [NCH-1:0]      pin_out,
  output logic [NCH-1:0]      pin_oe,
  output logic [NCH-1:0]      evt_irq,
  output logic [NCH-1:0]      ovr_irq
);

  // ==========================================================
  // Declarations
  chan_ctl_t         ctl_ff [NCH];
  logic [TW-1:0]     period_ff;
  logic [NCH-1:0]    chan_pend_ff;
  logic [NCH-1:0]    ovr_pend_ff;
  logic [NCH-1:0]    match_d_ff;
  logic [NCH-1:0]    pin_ff;
  logic [NCH-1:0]    oe_ff;
  logic [NCH-1:0]    evt_irq_ff;
  logic [NCH-1:0]    ovr_irq_ff;
  logic [DW-1:0]     prdata_ff;
  logic              pready_ff;
  logic              pslverr_ff;

  logic [TW-1:0]     time_q   [NCH];
  cap_state_t        state_q  [NCH];
  logic [NCH-1:0]    xfer;
  logic [NCH-1:0]    ovr;
  logic [NCH-1:0]    cap_edge;
  logic [NCH-1:0]    fire;
  logic [NCH-1:0]    match;
  logic [NCH-1:0]    paired;
  logic [NCH-1:0]    evt_set;
  logic [NCH-1:0]    nxt_pin;
  logic [NCH-1:0]    nxt_oe;
  logic [NCH-1:0]    buf_valid;
  logic [NCH-1:0]    time_valid;
  logic [DW-1:0]     nxt_prdata;

  logic              setup;
  logic              access;
  logic              wr;
  logic              rd;
  reg_sel_t          sel;

  // ==========================================================
  // Functions

  // Map a byte address to register region and channel
  function automatic reg_sel_t decode(input logic [AW-1:0] addr);
    reg_sel_t r;
    r.chan   = addr[CH_MSB:CH_LSB];
    r.region = RG_NONE;
    if (addr[ALIGN_MSB:0] != 2'h0)
      r.region = RG_NONE;
    else if (addr < ADDR_PEND)
      r.region = addr[REG_SEL_BIT] ? RG_TIME : RG_CTL;
    else if (addr == ADDR_PEND)
      r.region = RG_PEND;
    else if (addr == ADDR_PERIOD)
      r.region = RG_PERIOD;
    else if (addr == ADDR_STATUS)
      r.region = RG_STATUS;
    return r;
  endfunction

  // New pin level after a compare action
  function automatic logic apply_action(input logic lvl, input logic [1:0] act);
    case (act)
      ACT_HIGH:   return 1'b1;
      ACT_LOW:    return 1'b0;
      ACT_TOGGLE: return ~lvl;
      default:    return lvl;
    endcase
  endfunction

  // Pin that a channel acts on; paired channels share the even pin
  function automatic int pin_of(input int ch, input logic is_paired);
    return is_paired ? (ch - (ch % 2)) : ch;
  endfunction

  // ==========================================================
  // APB phase decode
  assign setup  = psel && !penable;
  assign access = psel && penable && pready_ff;
  assign wr     = access && pwrite;
  assign rd     = access && !pwrite;
  assign sel    = decode(paddr);

  // ==========================================================
  // Per-channel capture and compare datapath
  for (genvar ch = 0; ch < NCH; ch++)
  begin : g_chan
    logic [TW-1:0] tsel;
    logic          sw_load;
    logic          ts_load;
    logic          rd_clr;
    logic          disarm;
    logic [TW-1:0] ld_val;

    // Pairing bit lives on the odd channel of each pair
    assign paired[ch] = ctl_ff[ch | 1].pair;

    assign tsel = ctl_ff[ch].tmr_sel ? timer_b : timer_a;

    // Match is taken once per equality episode
    assign match[ch] = !ctl_ff[ch].capture && time_valid[ch] &&
                       (tsel == time_q[ch]);
    assign fire[ch]  = match[ch] && !match_d_ff[ch];

    // Software write of a new event time arms the channel
    assign sw_load = wr && (sel.region == RG_TIME) && (sel.chan == ch);
    // Remapped pair: move event time on by one period
    assign ts_load = fire[ch] && paired[ch];
    assign ld_val  = sw_load ? pwdata[TW-1:0] :
                     TW'(time_q[ch] + period_ff);
    // Read of the event time frees the slot in capture mode
    assign rd_clr  = rd && (sel.region == RG_TIME) && (sel.chan == ch) &&
                     ctl_ff[ch].capture;
    // One-shot compare disarms until the next write
    assign disarm  = fire[ch] && !ctl_ff[ch].rearm && !paired[ch];

    edge_qualifier #(
      .STABLE (STABLE_CYC)
    ) u_edge (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .pin_in     (pin_in[ch]),
      .edge_sel   (ctl_ff[ch].action),
      .edge_valid (cap_edge[ch])
    );

    capture_store u_store (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .overwrite (ctl_ff[ch].overwrite),
      .cap_edge  (cap_edge[ch] && ctl_ff[ch].capture),
      .timer_val (tsel),
      .clr       (rd_clr || disarm),
      .load_en   (sw_load || ts_load),
      .load_val  (ld_val),
      .time_q    (time_q[ch]),
      .state_q   (state_q[ch]),
      .xfer      (xfer[ch]),
      .ovr       (ovr[ch])
    );

    assign buf_valid[ch]  = state_q[ch][1];
    assign time_valid[ch] = state_q[ch][0];
    // Channel event: buffer transfer in capture, match in compare
    assign evt_set[ch]    = ctl_ff[ch].capture ? xfer[ch] : fire[ch];

    // Control register per channel
    always_ff @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
        ctl_ff[ch] <= chan_ctl_t'(CTL_RST);
      else if (wr && (sel.region == RG_CTL) && (sel.chan == ch))
        ctl_ff[ch] <= chan_ctl_t'(pwdata[CTL_W-1:0] & CTL_WMASK);
    end
  end

  // ==========================================================
  // Match history for single-shot detection per equality
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      match_d_ff <= '0;
    else
      match_d_ff <= match;
  end

  // ==========================================================
  // Pin actions and output enables
  always_comb
  begin
    nxt_pin = pin_ff;
    nxt_oe  = '0;
    for (int ch = 0; ch < NCH; ch++)
    begin
      if (fire[ch])
        nxt_pin[pin_of(ch, paired[ch])] =
          apply_action(nxt_pin[pin_of(ch, paired[ch])], ctl_ff[ch].action);
      // Odd channel of a pair drives through the even pin
      nxt_oe[ch] = !ctl_ff[ch].capture && !(paired[ch] && (ch % 2 == 1));
    end
  end

  // Pin level and enable registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_ff <= '0;
      oe_ff  <= '0;
    end
    else
    begin
      pin_ff <= nxt_pin;
      oe_ff  <= nxt_oe;
    end
  end

  // ==========================================================
  // Pending flags, write one to clear, set wins
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      chan_pend_ff <= '0;
      ovr_pend_ff  <= '0;
    end
    else if (wr && (sel.region == RG_PEND))
    begin
      chan_pend_ff <= (chan_pend_ff & ~pwdata[NCH-1:0]) | evt_set;
      ovr_pend_ff  <= (ovr_pend_ff & ~pwdata[PEND_OVR_LSB +: NCH]) | ovr;
    end
    else
    begin
      chan_pend_ff <= chan_pend_ff | evt_set;
      ovr_pend_ff  <= ovr_pend_ff | ovr;
    end
  end

  // Interrupt strobes gated by the channel enables
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      evt_irq_ff <= '0;
      ovr_irq_ff <= '0;
    end
    else
    begin
      for (int ch = 0; ch < NCH; ch++)
      begin
        evt_irq_ff[ch] <= evt_set[ch] && ctl_ff[ch].ch_ie;
        ovr_irq_ff[ch] <= ovr[ch] && ctl_ff[ch].ovr_ie;
      end
    end
  end

  // ==========================================================
  // Period constant for remapped pairs
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      period_ff <= PERIOD_RST;
    else if (wr && (sel.region == RG_PERIOD))
      period_ff <= pwdata[TW-1:0];
  end

  // ==========================================================
  // Read data mux
  always_comb
  begin
    nxt_prdata = '0;
    case (sel.region)
      RG_CTL:    nxt_prdata[CTL_W-1:0] = ctl_ff[sel.chan];
      RG_TIME:   nxt_prdata[TW-1:0] = time_q[sel.chan];
      RG_PEND:
      begin
        nxt_prdata[NCH-1:0] = chan_pend_ff;
        nxt_prdata[PEND_OVR_LSB +: NCH] = ovr_pend_ff;
      end
      RG_PERIOD: nxt_prdata[TW-1:0] = period_ff;
      RG_STATUS:
      begin
        nxt_prdata[NCH-1:0] = buf_valid;
        nxt_prdata[STAT_TV_LSB +: NCH] = time_valid;
        nxt_prdata[STAT_PIN_LSB +: NCH] = pin_ff;
      end
      default:   nxt_prdata = '0;
    endcase
  end

  // APB answer: ready in the first access cycle, data taken at setup
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end
    else
    begin
      pready_ff  <= setup;
      pslverr_ff <= setup && (sel.region == RG_NONE);
      if (setup && !pwrite)
        prdata_ff <= nxt_prdata;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign pin_out = pin_ff;
  assign pin_oe  = oe_ff;
  assign evt_irq = evt_irq_ff;
  assign ovr_irq = ovr_irq_ff;

endmodule

// ==== dv/event_processor_array_chk.sv ====
// Port checker for event_processor_array.
// Assumes the bind at the foot; sees only the top-level ports.

`timescale 1ns/1ps

module event_processor_array_chk
  import event_processor_array_pkg::*;
(
  input wire logic           clk,
  input wire logic           sys_rst,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [AW-1:0]  paddr,
  input wire logic [DW-1:0]  prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire logic [TW-1:0]  timer_a,
  input wire logic [TW-1:0]  timer_b,
  input wire logic [NCH-1:0] pin_in,
  input wire logic [NCH-1:0] pin_out,
  input wire logic [NCH-1:0] evt_irq,
  input wire logic [NCH-1:0] ovr_irq
);
  // ==========================================================
  // Activity tracking
  logic [NCH-1:0] pin_q_ff;
  logic [TW-1:0]  ta_q_ff;
  logic [TW-1:0]  tb_q_ff;
  logic [3:0]     pin_age_ff;
  logic [3:0]     act_age_ff;
  logic           pin_mv;
  logic           act_mv;

  // Pins, timers or a finished transfer moved this cycle
  assign pin_mv = pin_in != pin_q_ff;
  assign act_mv = pin_mv || timer_a != ta_q_ff || timer_b != tb_q_ff ||
                  (psel && penable && pready);

  // Delayed copies of pins and timers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_q_ff <= '0;
      ta_q_ff  <= '0;
      tb_q_ff  <= '0;
    end
    else
    begin
      pin_q_ff <= pin_in;
      ta_q_ff  <= timer_a;
      tb_q_ff  <= timer_b;
    end
  end

  // Saturating ages since the last pin move and the last activity
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_age_ff <= '0;
      act_age_ff <= '0;
    end
    else
    begin
      pin_age_ff <= pin_mv ? 4'h0 : pin_age_ff + {3'h0, pin_age_ff != 4'hF};
      act_age_ff <= act_mv ? 4'h0 : act_age_ff + {3'h0, act_age_ff != 4'hF};
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_ready_after_setup:
    assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  a_err_bad_addr:
    assert property (psel && !penable && (paddr[1:0] != 2'h0 || paddr > 8'h28) |=> pslverr)
    else $error("bad address not refused");
  a_err_good_addr:
    assert property (psel && !penable && paddr[1:0] == 2'h0 && paddr <= 8'h28 |=> !pslverr)
    else $error("good address refused");
  a_err_read_zero:
    assert property (pready && pslverr && !pwrite |-> prdata == '0)
    else $error("refused read returned data");
  a_reset_quiet:
    assert property ($fell(sys_rst) |-> pin_out == '0 && evt_irq == '0 && ovr_irq == '0)
    else $error("outputs not quiet after reset");
  a_ovr_from_pin:
    assert property (|ovr_irq |-> pin_age_ff <= 4'hA)
    else $error("overrun without a pin edge");
  a_ovr_one_pulse:
    assert property (|ovr_irq |=> (ovr_irq & $past(ovr_irq)) == '0)
    else $error("overrun pulse too long");
  a_evt_has_cause:
    assert property (|evt_irq |-> act_age_ff <= 4'hA)
    else $error("channel event without a cause");
  a_pin_on_match:
    assert property (pin_out != $past(pin_out) |-> act_age_ff <= 4'h4)
    else $error("pin moved without a match");
endmodule

bind event_processor_array event_processor_array_chk event_processor_array_chk_i (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_a(timer_a), .timer_b(timer_b), .pin_in(pin_in), .pin_out(pin_out),
  .evt_irq(evt_irq), .ovr_irq(ovr_irq));

// ==== dv/pin_partner.sv ====
// Model of the sources that drive the channel pins.
// Assumes the bench asks for levels; each stands HOLD cycles at least.

`timescale 1ns/1ps

module pin_partner
  import event_processor_array_pkg::*;
#(
  parameter int HOLD = 6
)
(
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic [NCH-1:0] level_req,
  output logic [NCH-1:0]      pin_in,
  output logic                settled
);
  logic [3:0] hold_ff;

  // Level may step only once the last one stood long enough
  assign settled = hold_ff >= 4'(HOLD);

  // Takes a requested level, then holds it steady
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_in  <= '0;
      hold_ff <= '0;
    end
    else if (settled && level_req != pin_in)
    begin
      pin_in  <= level_req;
      hold_ff <= '0;
    end
    else if (!settled)
    begin
      hold_ff <= hold_ff + 4'h1;
    end
  end
endmodule

// ==== dv/test_event_processor_array.sv ====
// Directed bench for event_processor_array over APB.
// Assumes pin_partner drives the pins and the bench drives both timers.

`timescale 1ns/1ps

module test_event_processor_array
  import event_processor_array_pkg::*;
();
  logic           clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic           settled, err;
  logic [AW-1:0]  paddr;
  logic [DW-1:0]  pwdata, prdata, rd;
  logic [TW-1:0]  timer_a, timer_b;
  logic [NCH-1:0] level_req, pin_in, pin_out, pin_oe, evt_irq, ovr_irq;
  logic [AW-1:0]  rst_addr [4] = '{ADDR_CTL0, ADDR_PEND, ADDR_PERIOD, ADDR_STATUS};
  int             bad_count, tests_run, e0, h0;
  int             evt_n = 0;
  int             ovr_n = 0;
  int             hi_n = 0;

  event_processor_array event_processor_array_i (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_a(timer_a), .timer_b(timer_b), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .evt_irq(evt_irq), .ovr_irq(ovr_irq));

  pin_partner pin_partner_i (
    .clk(clk), .sys_rst(sys_rst), .level_req(level_req), .pin_in(pin_in),
    .settled(settled));

  // ==========================================================
  // Clock and pulse counters
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Counts interrupt pulses and high cycles of pin 2
  always @(posedge clk)
  begin
    evt_n <= evt_n + $countones(evt_irq);
    ovr_n <= ovr_n + $countones(ovr_irq);
    hi_n  <= hi_n + int'(pin_out[2]);
  end

  // ==========================================================
  // Tasks
  task automatic close_out(input bit hung);
    if (hung)
      bad_count++;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      close_out(1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string nm);
    apb(1'b0, a, '0);
    check(nm, rd, exp);
  endtask

  // Asks the partner for a level and waits until it has stood
  task automatic pin_set(input logic [NCH-1:0] v);
    int n;
    n = 0;
    level_req <= v;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!(pin_in === v && settled === 1'b1) && n < 40);
    if (n >= 40)
      close_out(1'b1);
  endtask

  // Rising edge on pin 0 while timer_a holds v
  task automatic cap(input logic [TW-1:0] v);
    timer_a <= v;
    pin_set(4'h1);
    pin_set(4'h0);
  endtask

  // Counts one timer up from s for n cycles
  task automatic sweep(input logic [TW-1:0] s, input int n, input bit use_b);
    for (int k = 0; k < n; k++)
    begin
      if (use_b)
        timer_b <= s + TW'(k);
      else
        timer_a <= s + TW'(k);
      @(posedge clk);
    end
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = '0;
    timer_a = '0;
    timer_b = '0;
    level_req = '0;
    bad_count = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    foreach (rst_addr[i])
      rc(rst_addr[i], '0, "reset value");
    apb(1'b0, 8'h2C, '0);
    check("unmapped err", 32'(err), 32'h1);
    check("unmapped data", rd, '0);
    apb(1'b1, 8'h06, 32'h1);
    check("misaligned err", 32'(err), 32'h1);
    // Capture without overwrite: fill, overrun, drain
    wr(ADDR_CTL0, 32'h00D2);
    cap(16'h1111);
    rc(ADDR_STATUS, 32'h0010, "status time only");
    rc(ADDR_PEND, 32'h0001, "pend first");
    cap(16'h2222);
    rc(ADDR_STATUS, 32'h0011, "status both");
    cap(16'h3333);
    rc(ADDR_PEND, 32'h0011, "pend overrun");
    check("overrun pulses", 32'(ovr_n), 32'h1);
    wr(ADDR_PEND, 32'h0011);
    rc(ADDR_TIME0, 32'h1111, "first time");
    repeat (2) @(posedge clk);
    rc(ADDR_PEND, 32'h0001, "pend after read");
    rc(ADDR_TIME0, 32'h2222, "third ignored");
    check("capture events", 32'(evt_n), 32'h2);
    // Capture with overwrite
    wr(ADDR_CTL0, 32'h00D3);
    cap(16'h4444);
    cap(16'h5555);
    cap(16'h6666);
    rc(ADDR_TIME0, 32'h4444, "overwrite first");
    repeat (2) @(posedge clk);
    rc(ADDR_TIME0, 32'h6666, "overwrite last");
    // Compare on channel 1: toggle, one shot then re-arm
    e0 = evt_n;
    wr(8'h08, 32'h0074);
    wr(8'h0C, 32'h0050);
    sweep(16'h0040, 32, 1'b1);
    check("toggle once", 32'(pin_out[1]), 32'h1);
    sweep(16'h0040, 32, 1'b1);
    check("no re-arm", 32'(pin_out[1]), 32'h1);
    wr(8'h0C, 32'h0050);
    sweep(16'h0040, 32, 1'b1);
    check("after new time", 32'(pin_out[1]), 32'h0);
    wr(8'h08, 32'h007C);
    wr(8'h0C, 32'h0050);
    sweep(16'h0040, 32, 1'b1);
    check("re-arm first", 32'(pin_out[1]), 32'h1);
    sweep(16'h0040, 32, 1'b1);
    check("re-arm twice", 32'(pin_out[1]), 32'h0);
    check("toggle events", 32'(evt_n - e0), 32'h4);
    for (int act = 1; act <= 2; act++)
    begin
      wr(8'h08, 32'h000C | 32'(act << 4));
      wr(8'h0C, 32'h0050);
      sweep(16'h0040, 32, 1'b1);
      check("set or clear", 32'(pin_out[1]), 32'(act == 1));
    end
    // Paired channels 2 and 3, one count apart
    wr(ADDR_PERIOD, 32'h0010);
    wr(8'h10, 32'h0010);
    wr(8'h18, 32'h0120);
    wr(8'h14, 32'h0005);
    wr(8'h1C, 32'h0006);
    h0 = hi_n;
    sweep(16'h0000, 48, 1'b0);
    check("narrow pulses", 32'(hi_n - h0), 32'h3);
    check("odd pin off", 32'(pin_oe[3]), 32'h0);
    rc(8'h14, 32'h0035, "set time advanced");
    rc(8'h1C, 32'h0036, "clear time advanced");
    close_out(1'b0);
  end
endmodule
